// File: core/prt_pkg.sv
// Package of constants and types for the programmable ripple timer counter.
// Behaviour
// [R1] A trigger rising edge enables counting, drives all outputs low, starts the oscillator.
// [R2] The timebase gives one short low pulse per period, each counted.
// [R3] Binary variant counts straight binary; decimal variants use two cascaded digits.
// [R4] A high reset level ends the timing cycle at any count.
// [R5] In reset the timebase and counter stop and every output is released high.
// [R6] Only decimal variants have a carry output, high while in reset.
// [R7] Outputs wired back to reset give a self-ending monostable cycle.
// [R8] With no feedback the counter runs on and wraps after the first trigger.
// [R9] With the oscillator inhibited the counter counts the clock on the timebase pin.
// [R10] The outside keeps trigger high past the first falling external clock edge.
// [R11] Each counter output is an open-drain stage usable in a wired-AND.
// [R12] The seconds/minutes variant leaves its eighth output unconnected.
// [R13] Once triggered, further triggers are ignored until cycle end or reset.
// [R14] Trigger and reset together: trigger wins and a cycle starts; in a running cycle the code skips the reset and keeps counting.
// [R15] Decimal carry goes high during the last ten counts of the span.
// [R16] The device enters reset automatically at power-up.
// [R17] The counter advances on each falling timebase or external clock edge.
// [R18] The lower decimal digit wraps nine to zero and bumps the upper digit.
package prt_pkg;

	typedef enum logic [1:0] {
		PRT_BINARY = 2'h0,
		PRT_DECIMAL = 2'h1,
		PRT_SIXTY = 2'h2
	} prt_variant_t;

	typedef enum logic [1:0] {
		PRT_ST_RESET = 2'h1,
		PRT_ST_RUN = 2'h2
	} prt_state_t;

	localparam int PRT_CNT_W = 8;
	localparam logic [7:0] PRT_CNT_RST = 8'h00;
	localparam logic [3:0] PRT_DIGIT_LAST = 4'h9;
	localparam logic [3:0] PRT_UPPER_LAST_DEC = 4'h9;
	localparam logic [3:0] PRT_UPPER_LAST_SIX = 4'h5;
	// Default oscillator period in ns; the analog RC sets it in silicon.
	localparam int PRT_OSC_PERIOD_NS = 800;
	localparam int PRT_OSC_CYCLES = PRT_OSC_PERIOD_NS / 8;
	localparam int PRT_OSC_W = 16;

endpackage

// File: core/prt_tick_if.sv
// Interface carrying the count tick from the timebase to the counter.
`timescale 1ns/1ps
interface prt_tick_if;
	logic run;
	logic tick;
	logic tb_low;
	modport tb (input run, output tick, output tb_low);
	modport cnt (output run, input tick, input tb_low);
endinterface

// File: core/prt_timebase.sv
// Timebase: internal oscillator or external clock falling-edge detector.
`timescale 1ns/1ps
module prt_timebase
	import prt_pkg::*;
#(
	parameter int OSC_CYCLES = PRT_OSC_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic osc_inhibit,
	input wire logic ext_clk_in,
	prt_tick_if.tb tk
);
	logic [PRT_OSC_W-1:0] div_q;
	logic [PRT_OSC_W-1:0] div_d;
	logic ext_q;
	logic ext_d;
	logic pulse_q;
	logic pulse_d;

	always_comb
	begin
		div_d = div_q;
		pulse_d = 1'b0;
		ext_d = ext_clk_in;
		if (!tk.run || osc_inhibit)
		begin
			div_d = '0; // see [R5]
		end
		else if (div_q == PRT_OSC_W'(OSC_CYCLES - 1))
		begin
			div_d = '0;
			pulse_d = 1'b1; // see [R2]
		end
		else
		begin
			div_d = div_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			div_q <= '0;
			pulse_q <= 1'b0;
			ext_q <= 1'b1;
		end
		else if (clk_en)
		begin
			div_q <= div_d;
			pulse_q <= pulse_d;
			ext_q <= ext_d;
		end
	end

	// The pulse is one cycle low on the pin; counting happens at its falling edge.
	assign tk.tb_low = pulse_d;
	assign tk.tick = osc_inhibit ? (ext_q && !ext_clk_in && tk.run) : pulse_d; // see [R9] [R17]
endmodule

// File: core/prt_timer.sv
// Top level of the programmable ripple timer counter.
`timescale 1ns/1ps
module prt_timer
	import prt_pkg::*;
#(
	parameter prt_pkg::prt_variant_t VARIANT = prt_pkg::PRT_BINARY,
	parameter int OSC_CYCLES = prt_pkg::PRT_OSC_CYCLES
)
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Control inputs.
	input wire logic trigger,
	input wire logic reset_in,
	input wire logic osc_inhibit,
	// Timebase pin.
	input wire logic timebase_io_pin_in,
	output logic timebase_io_pin_out,
	output logic timebase_io_pin_oe,
	// Counter outputs, open drain.
	output logic [7:0] cnt_out,
	output logic [7:0] cnt_oe,
	// Carry.
	output logic carry_out,
	output logic carry_valid
);
	import prt_pkg::*;

	prt_tick_if tk();
	prt_state_t st_q;
	prt_state_t st_d;
	logic trig_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic carry_d;
	logic carry_q;
	logic [7:0] oe_d;
	logic [7:0] oe_q;
	logic tb_oe_q;

	prt_timebase #(.OSC_CYCLES(OSC_CYCLES)) u_tb (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.osc_inhibit(osc_inhibit),
		.ext_clk_in(timebase_io_pin_in),
		.tk(tk)
	);

	assign tk.run = (st_q == PRT_ST_RUN);

	////////////////////////////////////////////////////////////////////////////
	// Control and counting.

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			PRT_ST_RESET:
			begin
				if (trigger && !trig_q)
				begin
					st_d = PRT_ST_RUN; // see [R1] [R14]
					cnt_d = PRT_CNT_RST;
				end
			end
			PRT_ST_RUN:
			begin
				if (reset_in && !(trigger && !trig_q))
				begin
					st_d = PRT_ST_RESET; // see [R4] [R7] [R13]
					cnt_d = PRT_CNT_RST;
				end
				else if (tk.tick)
				begin
					if (VARIANT == PRT_BINARY)
					begin
						cnt_d = cnt_q + 8'h01; // see [R3] [R8]
					end
					else if (cnt_q[3:0] >= PRT_DIGIT_LAST)
					begin
						cnt_d[3:0] = 4'h0; // see [R18]
						if (cnt_q[7:4] >= ((VARIANT == PRT_SIXTY) ? PRT_UPPER_LAST_SIX
							: PRT_UPPER_LAST_DEC))
						begin
							cnt_d[7:4] = 4'h0; // see [R8]
						end
						else
						begin
							cnt_d[7:4] = cnt_q[7:4] + 4'h1;
						end
					end
					else
					begin
						cnt_d[3:0] = cnt_q[3:0] + 4'h1; // see [R3] [R17]
					end
				end
			end
			default:
			begin
				st_d = PRT_ST_RESET;
				cnt_d = PRT_CNT_RST;
			end
		endcase
		// Outputs conduct when the count bit is zero during a cycle, except output 7 of the PRT_SIXTY variant, which never conducts.
		oe_d = (st_d == PRT_ST_RUN) ? ~cnt_d : 8'h00; // see [R1] [R5] [R11]
		if (VARIANT == PRT_SIXTY)
		begin
			oe_d[7] = 1'b0; // see [R12]
		end
		carry_d = (st_d != PRT_ST_RUN) || (cnt_d[7:4] == ((VARIANT == PRT_SIXTY)
			? PRT_UPPER_LAST_SIX : PRT_UPPER_LAST_DEC)); // see [R6] [R15]
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			st_q <= PRT_ST_RESET; // see [R16]
			cnt_q <= PRT_CNT_RST;
			trig_q <= 1'b1;
			oe_q <= 8'h00;
			carry_q <= 1'b1;
			tb_oe_q <= 1'b0;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			trig_q <= trigger;
			oe_q <= oe_d;
			carry_q <= carry_d;
			tb_oe_q <= !osc_inhibit && tk.tb_low;
		end
	end

	assign cnt_out = 8'h00;
	assign cnt_oe = oe_q;
	assign timebase_io_pin_out = 1'b0;
	assign timebase_io_pin_oe = tb_oe_q; // see [R2]
	assign carry_out = (VARIANT == PRT_BINARY) ? 1'b0 : carry_q;
	assign carry_valid = (VARIANT != PRT_BINARY);
endmodule

// File: test/prt_monitor.sv
// Port checker of the timer counter.
`timescale 1ns/1ps
module prt_monitor
	import prt_pkg::*;
#(
	parameter prt_pkg::prt_variant_t VARIANT = prt_pkg::PRT_BINARY,
	parameter int OSC_CYCLES = 4
)
(
	input wire logic ref_clk, sys_rst, clk_en, trigger, reset_in, osc_inhibit,
	input wire logic timebase_io_pin_in, timebase_io_pin_out, timebase_io_pin_oe,
	input wire logic [7:0] cnt_out, cnt_oe,
	input wire logic carry_out, carry_valid
);
	logic [7:0] c;
	assign c = ~cnt_oe;
	// Decimal successor of a count.
	function automatic logic [7:0] nx(logic [7:0] p);
		return p[3:0] == 4'h9 ? {(p[7:4] == 4'h9 ? 4'h0 : p[7:4] + 4'h1), 4'h0} : p + 8'h01;
	endfunction
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_idle2;
		cnt_oe == 8'h00 ##1 cnt_oe == 8'h00;
	endsequence
	// The trigger edge is only seen by the design when the enable was high on both edges.
	property p_start;
		!$past(sys_rst) && clk_en && $past(clk_en) && cnt_oe == 8'h00 && $rose(trigger)
			|=> cnt_oe == 8'hFF;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_stop;
		clk_en && $past(clk_en) && reset_in && !$rose(trigger)
			|=> cnt_oe == 8'h00 && (carry_out || !carry_valid);
	endproperty
	a_stop: assert property (p_stop) else $error("no stop");
	property p_idle;
		s_idle2 |-> !timebase_io_pin_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("timebase in reset");
	property p_pulse;
		clk_en && timebase_io_pin_oe |=> !timebase_io_pin_oe;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_od;
		cnt_out == 8'h00 && !timebase_io_pin_out && (VARIANT != PRT_SIXTY || !cnt_oe[7]);
	endproperty
	a_od: assert property (p_od) else $error("driven high");
	property p_step;
		cnt_oe != 8'h00 && $past(cnt_oe) != 8'h00 && $changed(cnt_oe) && carry_valid
			|-> c == nx($past(c));
	endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_carry;
		carry_valid && cnt_oe != 8'h00 |-> carry_out == (c[7:4] == 4'h9);
	endproperty
	a_carry: assert property (p_carry) else $error("bad carry");
	property p_valid;
		carry_valid == (VARIANT != PRT_BINARY);
	endproperty
	a_valid: assert property (p_valid) else $error("bad carry valid");
endmodule
bind prt_timer prt_monitor #(.VARIANT(VARIANT), .OSC_CYCLES(OSC_CYCLES)) prt_monitor_i (.*);

// File: test/prt_far.sv
// External clock source and wired-AND feedback of the counter outputs.
`timescale 1ns/1ps
module prt_far
(
	input wire logic ref_clk, tb_oe,
	input wire logic [7:0] cnt_oe, sel,
	output logic pin, fb
);
	logic ext = 1'b1;
	assign pin = ext & ~tb_oe;
	assign fb = |sel & ~|(cnt_oe & sel);
	task automatic pulse(int n);
		repeat (n)
		begin
			@(negedge ref_clk) ext = 1'b0;
			repeat (2) @(negedge ref_clk);
			ext = 1'b1;
			repeat (2) @(negedge ref_clk);
		end
	endtask
endmodule

// File: test/tb.sv
// Self-checking testbench of the timer counter.
`timescale 1ns/1ps
module tb;
	import prt_pkg::*;
	logic ref_clk = 1'b0, sys_rst = 1'b1, trigger = 1'b0, rst_drv = 1'b0, osc_inhibit = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] sel = 8'h00, cnt_oe, cnt_out;
	logic pin, fb, tb_out, tb_oe, carry_out, carry_valid;
	int n_fail = 0, check_count = 0, n;
	always #4 ref_clk = ~ref_clk;
	prt_timer #(.VARIANT(PRT_DECIMAL), .OSC_CYCLES(4)) prt_timer_i (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .clk_en(clk_en), .trigger(trigger), .reset_in(rst_drv | fb),
		.osc_inhibit(osc_inhibit), .timebase_io_pin_in(pin), .timebase_io_pin_out(tb_out),
		.timebase_io_pin_oe(tb_oe), .cnt_out(cnt_out), .cnt_oe(cnt_oe),
		.carry_out(carry_out), .carry_valid(carry_valid));
	prt_far prt_far_i (.ref_clk(ref_clk), .tb_oe(tb_oe), .cnt_oe(cnt_oe), .sel(sel),
		.pin(pin), .fb(fb));
	task automatic cyc(int k);
		repeat (k) @(negedge ref_clk);
	endtask
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_ext;
		osc_inhibit = 1'b1;
		trigger = 1'b1;
		cyc(2);
		chk("start", cnt_oe, 8'hFF);
		prt_far_i.pulse(1);
		trigger = 1'b0;
		prt_far_i.pulse(24);
		chk("count 25", ~cnt_oe, 8'h25);
		chk("carry low", {7'h0, carry_out}, 8'h00);
		prt_far_i.pulse(70);
		trigger = 1'b1;
		chk("count 95", ~cnt_oe, 8'h95);
		chk("carry high", {7'h0, carry_out}, 8'h01);
		prt_far_i.pulse(5);
		chk("wrap", ~cnt_oe, 8'h00);
		rst_drv = 1'b1;
		cyc(2);
		chk("stop", cnt_oe, 8'h00);
		rst_drv = 1'b0;
		trigger = 1'b0;
		osc_inhibit = 1'b0;
	endtask
	task automatic t_prio;
		// Let the low trigger be sampled so that the next rise is a real edge.
		cyc(2);
		rst_drv = 1'b1;
		trigger = 1'b1;
		cyc(1);
		rst_drv = 1'b0;
		cyc(2);
		chk("priority", cnt_oe, 8'hFF);
		rst_drv = 1'b1;
		cyc(2);
		chk("reset", cnt_oe, 8'h00);
		rst_drv = 1'b0;
		trigger = 1'b0;
	endtask
	task automatic t_freeze;
		logic [7:0] v;
		cyc(2);
		trigger = 1'b1;
		cyc(2);
		trigger = 1'b0;
		cyc(10);
		clk_en = 1'b0;
		cyc(1);
		v = cnt_oe;
		cyc(20);
		chk("freeze", cnt_oe, v);
		clk_en = 1'b1;
		cyc(10);
		chk("resume", 8'(cnt_oe != v), 8'h01);
		rst_drv = 1'b1;
		cyc(2);
		chk("freeze stop", cnt_oe, 8'h00);
		rst_drv = 1'b0;
	endtask
	task automatic t_mono;
		sel = 8'h11;
		cyc(2);
		trigger = 1'b1;
		cyc(3);
		trigger = 1'b0;
		n = 3;
		while (cnt_oe !== 8'h00 && n < 200)
		begin
			cyc(1);
			n++;
		end
		chk("span", 8'(n >= 40 && n <= 52), 8'h01);
		chk("carry", {7'h0, carry_out}, 8'h01);
		sel = 8'h00;
	endtask
	initial
	begin
		#100000;
		n_fail++;
		tally_and_finish;
	end
	initial
	begin
		cyc(5);
		sys_rst = 1'b0;
		cyc(2);
		chk("power-up", cnt_oe, 8'h00);
		t_ext;
		t_prio;
		t_mono;
		t_freeze;
		tally_and_finish;
	end
endmodule
